// ===== pkg/fss_regs.svh
// Register offsets, fields, reset values and timing constants of the fan controller
// Summary of operation
// R1: Keep a target speed separate from the speed applied right now.
// R2: Target speed already respects the active limitation; step-up stays inside it. The code steps applied speed through excluded speeds too.
// R3: Update-only status outputs refresh their stored value but never transmit.
// R4: Send policies: on change (default), on request, or on either.
// R5: Three single-bit indicators, one each for speeds one to three.
// R6: One-byte status output holding the fan speed as a number.
// R7: Per-output bit picks applied speed (default) or target speed for reporting.
// R8: Operating-state byte: heating, cooling, automatic, forced and four limitations.
// R9: Fan-on bit rises as soon as the fan leaves OFF, before a speed.
// R10: Automatic status bit is 1 while automatic control runs, else 0.
// R11: Thresholds are compared in ascending order: OFF/1, then 1/2, then 2/3.
// R12: Software keeps the three thresholds strictly increasing.
// R13: Polarity bit selects whether a received 1 or 0 activates automatic.
// R14: Above OFF/1 threshold (default 10) speed 1 runs; below it the fan stops.
// R15: Above the 1/2 threshold (default 30) the fan moves to speed 2.
// R16: Above the 2/3 threshold (default 70) the fan moves to speed 3.
// R17: One hysteresis 0..20 for all thresholds: on at t+h, off below t-h.
// R18: In automatic mode each speed dwells 0..65535 seconds before stepping; zero means none.
// R19: State byte bits 0..3 heat, cool, auto, forced; bits 4..7 limitations.
// R20: Speed byte encodes OFF as 0 and speeds one to three as 1..3.
// R21: A request to an output without request sending causes no transmission.
`ifndef FSS_REGS_SVH
`define FSS_REGS_SVH
`define FSS_OFS_CTRL 8'h00
`define FSS_OFS_THRESH 8'h04
`define FSS_OFS_DWELL 8'h08
`define FSS_OFS_POLICY 8'h0C
`define FSS_OFS_DEMAND 8'h10
`define FSS_OFS_CMD 8'h14
`define FSS_OFS_LIMCFG 8'h18
`define FSS_OFS_REQ 8'h1C
`define FSS_OFS_STATUS 8'h20
`define FSS_CTRL_POL 0
`define FSS_CTRL_COOL 1
`define FSS_CTRL_EN 2
`define FSS_CTRL_MEAN_BITS 7
`define FSS_CTRL_MEAN_BYTE 8
`define FSS_CTRL_FSPD 9
`define FSS_THR_T1 0
`define FSS_THR_T2 8
`define FSS_THR_T3 16
`define FSS_THR_HYST 24
`define FSS_DEM_HEAT 0
`define FSS_DEM_COOL 8
`define FSS_CMD_AUTO 0
`define FSS_CMD_FORCE 1
`define FSS_CMD_LIM 4
`define FSS_ST_TGT 0
`define FSS_ST_APP 2
`define FSS_ST_FAN 4
`define FSS_ST_AUTO 5
`define FSS_ST_MODE 8
`define FSS_MB_HEAT 0
`define FSS_MB_COOL 1
`define FSS_MB_AUTO 2
`define FSS_MB_FORCE 3
`define FSS_MB_LIM 4
`define FSS_RST_CTRL 32'h0000_0001
`define FSS_RST_THRESH 32'h0546_1E0A
`define FSS_RST_DWELL 32'h0000_001E
`define FSS_RST_POLICY 32'h0000_0000
`define FSS_RST_LIMCFG 32'h0000_FFFF
`define FSS_NOBJ 5
`define FSS_OBJ_BITS 0
`define FSS_OBJ_BYTE 1
`define FSS_OBJ_MODE 2
`define FSS_OBJ_FAN 3
`define FSS_OBJ_AUTO 4
`define FSS_CLK_HZ 50000000
`define FSS_DWELL_UNIT_S 1
`endif

// ===== pkg/fss_pkg.sv
// Types shared by the fan controller modules
package fss_pkg;
  typedef enum logic [1:0] {fss_off, fss_s1, fss_s2, fss_s3} fss_speed_t;
  typedef enum logic [1:0] {
    fss_pol_change,
    fss_pol_update,
    fss_pol_request,
    fss_pol_both
  } fss_policy_t;
endpackage

// ===== pkg/fss_stat_if.sv
// Carrier between the controller and one status sender
`timescale 1ns/1ps
interface fss_stat_if;
  logic [7:0] value;
  fss_pkg::fss_policy_t policy;
  logic enable;
  logic req;
  logic [7:0] stored;
  logic send;
  modport owner(output value, output policy, output enable, output req,
    input stored, input send);
  modport sender(input value, input policy, input enable, input req,
    output stored, output send);
endinterface

// ===== logic/fss_status_send.sv
// One status object: stored value and its send policy
`timescale 1ns/1ps
module fss_status_send (
  // Clock and reset
  input logic sys_clk,
  input logic rst_b,
  input logic clk_en,
  // Object
  fss_stat_if.sender port
);
  logic [7:0] stored_reg, stored_next;
  logic send_reg, send_next;
  logic changed;

  always_comb begin
    changed = port.value != stored_reg;
    stored_next = port.value; // R3
    send_next = 1'b0;
    if (port.enable) begin
      unique case (port.policy)
        fss_pkg::fss_pol_change: send_next = changed; // R4
        fss_pkg::fss_pol_update: send_next = 1'b0; // R3
        fss_pkg::fss_pol_request: send_next = port.req; // R4 R21
        fss_pkg::fss_pol_both: send_next = changed || port.req; // R4
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      stored_reg <= 8'h00;
      send_reg <= 1'b0;
    end else if (clk_en) begin
      stored_reg <= stored_next;
      send_reg <= send_next;
    end
  end

  assign port.stored = stored_reg;
  assign port.send = send_reg;

  upd_only_quiet_a: assert property ( // R3
    @(posedge sys_clk) disable iff (!rst_b)
    (clk_en && port.policy == fss_pkg::fss_pol_update) |=> !port.send)
    else $error("update-only object transmitted");

  req_gives_send_a: assert property ( // R4
    @(posedge sys_clk) disable iff (!rst_b)
    (clk_en && port.enable && port.req && port.policy == fss_pkg::fss_pol_both)
      |=> port.send)
    else $error("request not answered");

  req_ignored_a: assert property ( // R21
    @(posedge sys_clk) disable iff (!rst_b)
    (clk_en && port.req && port.policy == fss_pkg::fss_pol_change && !changed)
      |=> !port.send)
    else $error("request sent under change-only policy");
endmodule

// ===== logic/fss_fan_ctrl.sv
// Automatic three-speed fan controller with status objects and register port
//
// Chosen here: the address map and strobed register access.
`timescale 1ns/1ps
`include "fss_regs.svh"
module fss_fan_ctrl #(
  parameter int TICK_CYCLES = `FSS_CLK_HZ * `FSS_DWELL_UNIT_S,
  parameter int DWELL_W = 16
) (
  // Clock and reset
  input logic sys_clk,
  input logic rst_b,
  input logic clk_en,
  // Register port
  input logic [7:0] reg_addr,
  input logic [31:0] reg_wdata,
  input logic reg_wr,
  input logic reg_rd,
  output logic [31:0] reg_rdata,
  // Speeds
  output logic [1:0] target_speed,
  output logic [1:0] applied_speed,
  // Status objects
  output logic [2:0] stat_speed_bits,
  output logic [7:0] stat_speed_byte,
  output logic [7:0] stat_mode_byte,
  output logic stat_fan_on,
  output logic stat_auto,
  output logic [`FSS_NOBJ-1:0] tx_send
);
  logic [31:0] ctrl_reg, ctrl_next;
  logic [31:0] thresh_reg, thresh_next;
  logic [31:0] dwell_reg, dwell_next;
  logic [31:0] policy_reg, policy_next;
  logic [31:0] demand_reg, demand_next;
  logic [31:0] cmd_reg, cmd_next;
  logic [31:0] limcfg_reg, limcfg_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [`FSS_NOBJ-1:0] req_vec;

  fss_pkg::fss_speed_t auto_spd_reg, auto_spd_next;
  fss_pkg::fss_speed_t target_reg, target_next;
  fss_pkg::fss_speed_t applied_reg, applied_next;
  logic [31:0] pre_reg, pre_next;
  logic [DWELL_W-1:0] sec_reg, sec_next;

  logic [7:0] cv;
  logic [7:0] hyst;
  logic auto_on;
  logic forced;
  logic [3:0] lim_act;
  logic [3:0] cur_mask;
  logic step_ok;
  logic fan_on;
  logic [7:0] mode_byte;
  fss_pkg::fss_speed_t lvl;
  fss_pkg::fss_speed_t bits_spd;
  fss_pkg::fss_speed_t byte_spd;

  // Threshold i sits above speed i
  function automatic logic [7:0] thr_at(
    input logic [31:0] thr,
    input logic [1:0] i
  );
    logic [7:0] t;
    t = thr[`FSS_THR_T3 +: 8];
    if (i == 2'h0) begin
      t = thr[`FSS_THR_T1 +: 8];
    end else if (i == 2'h1) begin
      t = thr[`FSS_THR_T2 +: 8];
    end
    return t;
  endfunction

  // Plain level without hysteresis, thresholds taken from the bottom up
  function automatic fss_pkg::fss_speed_t level_of(
    input logic [7:0] v,
    input logic [31:0] thr
  );
    fss_pkg::fss_speed_t s;
    s = fss_pkg::fss_off;
    if (v > thr[`FSS_THR_T1 +: 8]) begin // R11 R14
      s = fss_pkg::fss_s1;
    end
    if (v > thr[`FSS_THR_T2 +: 8]) begin // R11 R15
      s = fss_pkg::fss_s2;
    end
    if (v > thr[`FSS_THR_T3 +: 8]) begin // R11 R16
      s = fss_pkg::fss_s3;
    end
    return s;
  endfunction

  // Nearest allowed speed: prefer below, else above; empty mask means free
  function automatic fss_pkg::fss_speed_t clamp(
    input fss_pkg::fss_speed_t s,
    input logic [3:0] m
  );
    fss_pkg::fss_speed_t r;
    logic found;
    r = s;
    found = 1'b0;
    if (m != 4'h0 && !m[s]) begin
      for (int i = 0; i < 4; i++) begin
        if (m[i] && i < int'(s)) begin
          r = fss_pkg::fss_speed_t'(2'(i));
          found = 1'b1;
        end
      end
      for (int i = 3; i >= 0; i--) begin
        if (!found && m[i] && i > int'(s)) begin
          r = fss_pkg::fss_speed_t'(2'(i));
        end
      end
    end
    return r;
  endfunction

  // Register file
  always_comb begin
    ctrl_next = ctrl_reg;
    thresh_next = thresh_reg;
    dwell_next = dwell_reg;
    policy_next = policy_reg;
    demand_next = demand_reg;
    cmd_next = cmd_reg;
    limcfg_next = limcfg_reg;
    req_vec = '0;
    rdata_next = 32'h0000_0000;
    if (reg_wr) begin
      unique case (reg_addr)
        `FSS_OFS_CTRL: ctrl_next = reg_wdata;
        `FSS_OFS_THRESH: thresh_next = reg_wdata;
        `FSS_OFS_DWELL: dwell_next = reg_wdata;
        `FSS_OFS_POLICY: policy_next = reg_wdata;
        `FSS_OFS_DEMAND: demand_next = reg_wdata;
        `FSS_OFS_CMD: cmd_next = reg_wdata;
        `FSS_OFS_LIMCFG: limcfg_next = reg_wdata;
        `FSS_OFS_REQ: req_vec = reg_wdata[`FSS_NOBJ-1:0];
        default: ;
      endcase
    end
    if (reg_rd) begin
      unique case (reg_addr)
        `FSS_OFS_CTRL: rdata_next = ctrl_reg;
        `FSS_OFS_THRESH: rdata_next = thresh_reg;
        `FSS_OFS_DWELL: rdata_next = dwell_reg;
        `FSS_OFS_POLICY: rdata_next = policy_reg;
        `FSS_OFS_DEMAND: rdata_next = demand_reg;
        `FSS_OFS_CMD: rdata_next = cmd_reg;
        `FSS_OFS_LIMCFG: rdata_next = limcfg_reg;
        `FSS_OFS_STATUS: begin
          rdata_next[`FSS_ST_TGT +: 2] = target_reg;
          rdata_next[`FSS_ST_APP +: 2] = applied_reg;
          rdata_next[`FSS_ST_FAN] = fan_on;
          rdata_next[`FSS_ST_AUTO] = auto_on;
          rdata_next[`FSS_ST_MODE +: 8] = mode_byte;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_reg <= `FSS_RST_CTRL;
      thresh_reg <= `FSS_RST_THRESH;
      dwell_reg <= `FSS_RST_DWELL;
      policy_reg <= `FSS_RST_POLICY;
      demand_reg <= 32'h0000_0000;
      cmd_reg <= 32'h0000_0000;
      limcfg_reg <= `FSS_RST_LIMCFG;
      rdata_reg <= 32'h0000_0000;
    end else if (clk_en) begin
      ctrl_reg <= ctrl_next;
      thresh_reg <= thresh_next;
      dwell_reg <= dwell_next;
      policy_reg <= policy_next;
      demand_reg <= demand_next;
      cmd_reg <= cmd_next;
      limcfg_reg <= limcfg_next;
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;

  // Fan control
  always_comb begin
    cv = ctrl_reg[`FSS_CTRL_COOL] ? demand_reg[`FSS_DEM_COOL +: 8]
                                  : demand_reg[`FSS_DEM_HEAT +: 8];
    hyst = thresh_reg[`FSS_THR_HYST +: 8];
    auto_on = cmd_reg[`FSS_CMD_AUTO] == ctrl_reg[`FSS_CTRL_POL]; // R13
    forced = cmd_reg[`FSS_CMD_FORCE];
    // Limitations only act while automatic runs
    lim_act = auto_on ? cmd_reg[`FSS_CMD_LIM +: 4] : 4'h0;
    cur_mask = 4'h0;
    for (int i = 3; i >= 0; i--) begin
      if (lim_act[i]) begin
        cur_mask = limcfg_reg[4*i +: 4];
      end
    end
    lvl = level_of(cv, thresh_reg);
    auto_spd_next = auto_spd_reg;
    if (auto_on) begin
      if (cv == 8'h00) begin
        auto_spd_next = fss_pkg::fss_off; // R14
      end else if (auto_spd_reg != fss_pkg::fss_s3 &&
          {1'b0, cv} >= {1'b0, thr_at(thresh_reg, auto_spd_reg)} + {1'b0, hyst}) begin
        auto_spd_next = lvl; // R17
      end else if (auto_spd_reg != fss_pkg::fss_off &&
          {1'b0, cv} + {1'b0, hyst} <
          {1'b0, thr_at(thresh_reg, 2'(auto_spd_reg - 2'h1))}) begin
        auto_spd_next = lvl; // R17
      end
    end
    target_next = target_reg;
    if (forced) begin
      target_next = fss_pkg::fss_speed_t'(ctrl_reg[`FSS_CTRL_FSPD +: 2]);
    end else if (auto_on) begin
      target_next = clamp(auto_spd_next, cur_mask); // R1 R2
    end
    // Dwell applies in automatic mode only; zero means immediate
    step_ok = !auto_on || dwell_reg[DWELL_W-1:0] == '0 ||
              sec_reg >= dwell_reg[DWELL_W-1:0]; // R18
    applied_next = applied_reg;
    pre_next = pre_reg;
    sec_next = sec_reg;
    if (applied_reg != target_reg && step_ok) begin
      if (applied_reg < target_reg) begin
        applied_next = fss_pkg::fss_speed_t'(2'(applied_reg + 2'h1)); // R1
      end else begin
        applied_next = fss_pkg::fss_speed_t'(2'(applied_reg - 2'h1)); // R1
      end
      pre_next = 32'h0000_0000;
      sec_next = '0;
    end else if (pre_reg >= 32'(TICK_CYCLES - 1)) begin
      pre_next = 32'h0000_0000;
      if (sec_reg != '1) begin
        sec_next = sec_reg + 1'b1;
      end
    end else begin
      pre_next = pre_reg + 32'h0000_0001;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      auto_spd_reg <= fss_pkg::fss_off;
      target_reg <= fss_pkg::fss_off;
      applied_reg <= fss_pkg::fss_off;
      pre_reg <= 32'h0000_0000;
      sec_reg <= '0;
    end else if (clk_en) begin
      auto_spd_reg <= auto_spd_next;
      target_reg <= target_next;
      applied_reg <= applied_next;
      pre_reg <= pre_next;
      sec_reg <= sec_next;
    end
  end

  assign target_speed = target_reg;
  assign applied_speed = applied_reg;

  // Status values
  always_comb begin
    // Fan-on leads the applied speed so a main switch can close first
    fan_on = target_reg != fss_pkg::fss_off ||
             applied_reg != fss_pkg::fss_off; // R9
    bits_spd = ctrl_reg[`FSS_CTRL_MEAN_BITS] ? target_reg : applied_reg; // R7
    byte_spd = ctrl_reg[`FSS_CTRL_MEAN_BYTE] ? target_reg : applied_reg; // R7
    mode_byte = 8'h00;
    mode_byte[`FSS_MB_HEAT] = !ctrl_reg[`FSS_CTRL_COOL]; // R8 R19
    mode_byte[`FSS_MB_COOL] = ctrl_reg[`FSS_CTRL_COOL]; // R8 R19
    mode_byte[`FSS_MB_AUTO] = auto_on; // R19
    mode_byte[`FSS_MB_FORCE] = forced; // R19
    mode_byte[`FSS_MB_LIM +: 4] = lim_act; // R19
  end

  fss_stat_if so [`FSS_NOBJ] ();

  assign so[`FSS_OBJ_BITS].value = {5'h00, bits_spd == fss_pkg::fss_s3,
    bits_spd == fss_pkg::fss_s2, bits_spd == fss_pkg::fss_s1}; // R5
  assign so[`FSS_OBJ_BYTE].value = {6'h00, byte_spd}; // R6 R20
  assign so[`FSS_OBJ_MODE].value = mode_byte; // R8
  assign so[`FSS_OBJ_FAN].value = {7'h00, fan_on}; // R9
  assign so[`FSS_OBJ_AUTO].value = {7'h00, auto_on}; // R10

  for (genvar g = 0; g < `FSS_NOBJ; g++) begin : g_obj
    assign so[g].policy = fss_pkg::fss_policy_t'(policy_reg[2*g +: 2]);
    assign so[g].enable = ctrl_reg[`FSS_CTRL_EN + g];
    assign so[g].req = req_vec[g];
    assign tx_send[g] = so[g].send;
    fss_status_send u_send (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .clk_en(clk_en),
      .port(so[g].sender)
    );
  end

  assign stat_speed_bits = so[`FSS_OBJ_BITS].stored[2:0];
  assign stat_speed_byte = so[`FSS_OBJ_BYTE].stored;
  assign stat_mode_byte = so[`FSS_OBJ_MODE].stored;
  assign stat_fan_on = so[`FSS_OBJ_FAN].stored[0];
  assign stat_auto = so[`FSS_OBJ_AUTO].stored[0];

  fan_on_lead_a: assert property ( // R9
    @(posedge sys_clk) disable iff (!rst_b)
    (clk_en && target_reg != fss_pkg::fss_off) |=> stat_fan_on)
    else $error("fan-on missing while target not off");

  lim_target_a: assert property ( // R2
    @(posedge sys_clk) disable iff (!rst_b)
    (clk_en && auto_on && !forced && cur_mask != 4'h0)
      |=> (($past(cur_mask) >> target_reg) & 4'h1) != 4'h0)
    else $error("target outside active limitation");

  step_single_a: assert property ( // R1
    @(posedge sys_clk) disable iff (!rst_b)
    ##1 ({1'b0, applied_reg} == {1'b0, $past(applied_reg)} ||
     {1'b0, applied_reg} == {1'b0, $past(applied_reg)} + 3'h1 ||
     {1'b0, applied_reg} + 3'h1 == {1'b0, $past(applied_reg)}))
    else $error("applied speed jumped");

  dwell_hold_a: assert property ( // R18
    @(posedge sys_clk) disable iff (!rst_b)
    ($changed(applied_reg) && $past(auto_on) && $past(dwell_reg) != 32'h0)
      |-> $past(sec_reg) >= $past(dwell_reg[DWELL_W-1:0]))
    else $error("speed stepped before dwell ended");

  auto_status_a: assert property ( // R10
    @(posedge sys_clk) disable iff (!rst_b)
    $past(clk_en) |-> stat_auto == $past(auto_on))
    else $error("automatic status wrong");

  zero_off_a: assert property ( // R14
    @(posedge sys_clk) disable iff (!rst_b)
    (clk_en && auto_on && !forced && lim_act == 4'h0 && cv == 8'h00)
      |=> target_reg == fss_pkg::fss_off)
    else $error("zero demand did not stop fan");

  top_speed_a: assert property ( // R16
    @(posedge sys_clk) disable iff (!rst_b)
    (clk_en && auto_on && !forced && lim_act == 4'h0 && hyst == 8'h00 &&
     cv > thresh_reg[`FSS_THR_T3 +: 8] &&
     thresh_reg[`FSS_THR_T1 +: 8] < thresh_reg[`FSS_THR_T2 +: 8] &&
     thresh_reg[`FSS_THR_T2 +: 8] < thresh_reg[`FSS_THR_T3 +: 8])
      |=> target_reg == fss_pkg::fss_s3)
    else $error("speed 3 not reached");

  speed_byte_a: assert property ( // R20
    @(posedge sys_clk) disable iff (!rst_b)
    $past(clk_en) |-> stat_speed_byte == {6'h00, $past(byte_spd)})
    else $error("speed byte encoding wrong");
endmodule

// ===== tb/fss_bus_model.sv
// Far-side bus model: counts the telegrams each status object puts on the bus
`timescale 1ns/1ps
`include "fss_regs.svh"
module fss_bus_model (
  // Clock and reset
  input logic sys_clk,
  input logic rst_b,
  // Telegram strobes from the device
  input logic [`FSS_NOBJ-1:0] tx_send,
  // Telegram counts per object
  output logic [7:0] tx_cnt [`FSS_NOBJ]
);
  // Counts are never cleared after reset and wrap at 255, so the bench compares against a baseline it took itself
  always @(posedge sys_clk or negedge rst_b) begin
    for (int g = 0; g < `FSS_NOBJ; g++) begin
      if (!rst_b) begin
        tx_cnt[g] <= 8'h00;
      end else if (tx_send[g]) begin
        tx_cnt[g] <= tx_cnt[g] + 8'h01;
      end
    end
  end
endmodule

// ===== tb/tb_fan_speed_status_auto.sv
// Self-checking bench for the automatic three-speed fan controller
`timescale 1ns/1ps
`include "fss_regs.svh"
module tb_fan_speed_status_auto;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic clk_en = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [1:0] target_speed;
  logic [1:0] applied_speed;
  logic [2:0] stat_speed_bits;
  logic [7:0] stat_speed_byte;
  logic [7:0] stat_mode_byte;
  logic stat_fan_on;
  logic stat_auto;
  logic [`FSS_NOBJ-1:0] tx_send;
  logic [7:0] tx_cnt [`FSS_NOBJ];
  int num_errors = 0;
  int checks = 0;

  always #10 sys_clk = ~sys_clk;

  // Short tick keeps dwell times to a few cycles per second
  fss_fan_ctrl #(.TICK_CYCLES(4), .DWELL_W(16)) dut (
    .sys_clk(sys_clk), .rst_b(rst_b), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .target_speed(target_speed), .applied_speed(applied_speed),
    .stat_speed_bits(stat_speed_bits), .stat_speed_byte(stat_speed_byte),
    .stat_mode_byte(stat_mode_byte), .stat_fan_on(stat_fan_on), .stat_auto(stat_auto),
    .tx_send(tx_send)
  );

  fss_bus_model bus (.sys_clk(sys_clk), .rst_b(rst_b), .tx_send(tx_send), .tx_cnt(tx_cnt));

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  // Read data is only valid in the cycle right after the strobe edge
  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk(what, reg_rdata, exp);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic t_reset();
    rdchk("ctrl", `FSS_OFS_CTRL, `FSS_RST_CTRL);
    rdchk("thresh", `FSS_OFS_THRESH, `FSS_RST_THRESH);
    rdchk("dwell", `FSS_OFS_DWELL, `FSS_RST_DWELL);
    rdchk("policy", `FSS_OFS_POLICY, `FSS_RST_POLICY);
    rdchk("limcfg", `FSS_OFS_LIMCFG, `FSS_RST_LIMCFG);
    rdchk("demand", `FSS_OFS_DEMAND, 32'h0);
    rdchk("cmd", `FSS_OFS_CMD, 32'h0);
    rdchk("req", `FSS_OFS_REQ, 32'h0);
    rdchk("unmapped", 8'h24, 32'h0);
    rdchk("status", `FSS_OFS_STATUS, 32'h0000_0100);
  endtask

  task automatic t_thresh();
    logic [7:0] dem [8] = '{8'h0E, 8'h0F, 8'h28, 8'h4A, 8'h4B, 8'h42, 8'h40, 8'h00};
    logic [1:0] exp [8] = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h3, 2'h3, 2'h2, 2'h0};
    logic [2:0] bits;
    wr(`FSS_OFS_THRESH, 32'h0546_1E0A);
    wr(`FSS_OFS_DWELL, 32'h0);
    wr(`FSS_OFS_CTRL, 32'h7D);
    wr(`FSS_OFS_CMD, 32'h1);
    cyc(4);
    chk("auto_on", 32'(stat_auto), 32'h1);
    chk("mode_auto", 32'(stat_mode_byte), 32'h05);
    // Hysteresis 5 around 10/30/70: just below and on switch-on levels 15 and 75, then either side of 65 going down
    for (int i = 0; i < 8; i++) begin
      wr(`FSS_OFS_DEMAND, 32'(dem[i]));
      cyc(8);
      bits = (exp[i] == 2'h0) ? 3'h0 : (3'h1 << (exp[i] - 2'h1));
      chk("target", 32'(target_speed), 32'(exp[i]));
      chk("applied", 32'(applied_speed), 32'(exp[i]));
      chk("speed_byte", 32'(stat_speed_byte), 32'(exp[i]));
      chk("speed_bits", 32'(stat_speed_bits), 32'(bits));
      chk("fan_on", 32'(stat_fan_on), 32'(exp[i] != 2'h0));
    end
  endtask

  task automatic t_polarity();
    wr(`FSS_OFS_CTRL, 32'h7C);
    wr(`FSS_OFS_CMD, 32'h0);
    cyc(4);
    chk("auto_low_pol", 32'(stat_auto), 32'h1);
    wr(`FSS_OFS_CMD, 32'h1);
    cyc(4);
    chk("auto_off", 32'(stat_auto), 32'h0);
    chk("mode_no_auto", 32'(stat_mode_byte), 32'h01);
    wr(`FSS_OFS_CTRL, 32'h7D);
    cyc(4);
    chk("auto_back", 32'(stat_auto), 32'h1);
  endtask

  task automatic t_dwell();
    // Bits report the target, the byte keeps reporting the applied speed
    wr(`FSS_OFS_CTRL, 32'hFD);
    wr(`FSS_OFS_DWELL, 32'h2);
    wr(`FSS_OFS_DEMAND, 32'h50);
    cyc(4);
    chk("target_early", 32'(target_speed), 32'h3);
    chk("applied_held", 32'(applied_speed == 2'h3), 32'h0);
    chk("byte_applied", 32'(stat_speed_byte == 8'h03), 32'h0);
    chk("bits_target", 32'(stat_speed_bits), 32'h4);
    chk("fan_on_early", 32'(stat_fan_on), 32'h1);
    cyc(60);
    chk("applied_late", 32'(applied_speed), 32'h3);
    chk("byte_late", 32'(stat_speed_byte), 32'h3);
  endtask

  task automatic t_limit();
    wr(`FSS_OFS_DWELL, 32'h0);
    wr(`FSS_OFS_CTRL, 32'h7D);
    wr(`FSS_OFS_LIMCFG, 32'h0006);
    wr(`FSS_OFS_DEMAND, 32'h32);
    cyc(8);
    chk("lim_start", 32'(target_speed), 32'h2);
    wr(`FSS_OFS_CMD, 32'h11);
    wr(`FSS_OFS_DEMAND, 32'h5A);
    cyc(8);
    chk("lim_hold", 32'(target_speed), 32'h2);
    for (int k = 0; k < 4; k++) begin
      wr(`FSS_OFS_CMD, 32'h01 | (32'h10 << k));
      cyc(4);
      chk("mode_lim", 32'(stat_mode_byte), 32'h05 | (32'h10 << k));
    end
    wr(`FSS_OFS_CMD, 32'h01);
    cyc(8);
    chk("lim_free", 32'(target_speed), 32'h3);
    wr(`FSS_OFS_CMD, 32'h13);
    cyc(4);
    chk("mode_forced", 32'(stat_mode_byte), 32'h1D);
    wr(`FSS_OFS_CTRL, 32'h27F);
    cyc(4);
    chk("mode_cool", 32'(stat_mode_byte), 32'h1E);
    chk("forced_speed", 32'(target_speed), 32'h1);
    wr(`FSS_OFS_CMD, 32'h01);
    wr(`FSS_OFS_CTRL, 32'h7D);
  endtask

  // Pass 4 repeats change-or-request with the object disabled
  task automatic t_policy();
    logic cur;
    logic [1:0] pol;
    logic en;
    logic [7:0] base;
    cur = 1'b1;
    for (int p = 0; p < 5; p++) begin
      pol = (p == 4) ? 2'h3 : 2'(p);
      en = (p != 4);
      wr(`FSS_OFS_CTRL, en ? 32'h7D : 32'h3D);
      wr(`FSS_OFS_POLICY, 32'(pol) << 8);
      cyc(4);
      base = tx_cnt[4];
      cur = ~cur;
      wr(`FSS_OFS_CMD, 32'(cur));
      cyc(4);
      chk("auto_stored", 32'(stat_auto), 32'(cur));
      chk("tx_change", 32'(tx_cnt[4] - base), 32'(en && (pol == 2'h0 || pol == 2'h3)));
      base = tx_cnt[4];
      wr(`FSS_OFS_REQ, 32'h10);
      cyc(4);
      chk("tx_request", 32'(tx_cnt[4] - base), 32'(en && pol[1]));
    end
  endtask

  // Zero hysteresis: thresholds 10 and 30 are crossed both ways, 70 only going down
  task automatic t_hyst0();
    logic [7:0] dem [6] = '{8'h47, 8'h45, 8'h1D, 8'h09, 8'h0B, 8'h1F};
    logic [1:0] exp [6] = '{2'h3, 2'h2, 2'h1, 2'h0, 2'h1, 2'h2};
    wr(`FSS_OFS_CMD, 32'h1);
    wr(`FSS_OFS_THRESH, 32'h0046_1E0A);
    for (int i = 0; i < 6; i++) begin
      wr(`FSS_OFS_DEMAND, 32'(dem[i]));
      cyc(8);
      chk("target_h0", 32'(target_speed), 32'(exp[i]));
      chk("applied_h0", 32'(applied_speed), 32'(exp[i]));
    end
  endtask

  // A write while the clock enable is low must not land
  task automatic t_freeze();
    @(posedge sys_clk);
    clk_en <= 1'b0;
    wr(`FSS_OFS_DEMAND, 32'h0);
    cyc(4);
    chk("frozen_target", 32'(target_speed), 32'h2);
    @(posedge sys_clk);
    clk_en <= 1'b1;
    cyc(4);
    chk("thawed_target", 32'(target_speed), 32'h2);
    rdchk("frozen_demand", `FSS_OFS_DEMAND, 32'h1F);
  endtask

  task automatic stop_test();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk);
    num_errors++;
    stop_test();
  end

  initial begin
    repeat (6) @(posedge sys_clk);
    rst_b <= 1'b1;
    t_reset();
    t_thresh();
    t_polarity();
    t_dwell();
    t_limit();
    t_policy();
    t_hyst0();
    t_freeze();
    stop_test();
  end
endmodule
